// file: can_ctrl_pkg.sv
// package: register map, field layout and timing constants of the can control block
package can_ctrl_pkg;
    // word offsets of the three registers (byte addresses)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CFG_OFS = 8'h10;
    localparam logic [7:0] INT_OFS = 8'h20;
    // alias sub-offsets: plain, clear, set, invert
    localparam logic [1:0] ALIAS_PLAIN = 2'h0;
    localparam logic [1:0] ALIAS_CLR = 2'h1;
    localparam logic [1:0] ALIAS_SET = 2'h2;
    localparam logic [1:0] ALIAS_INV = 2'h3;

    // control register fields
    localparam int REQ_MODE_LSB = 24;
    localparam int OP_MODE_LSB = 21;
    localparam int ON_BIT = 15;
    localparam int STOP_IDLE_BIT = 13;
    localparam int ACTIVE_BIT = 11;
    localparam int DCNT_LSB = 0;
    // writable bits of the control register (requested mode, on, stop in idle, count)
    localparam logic [31:0] CTRL_WMASK = 32'h0700_a01f;
    localparam logic [31:0] CTRL_RESET = 32'h0400_0000;

    // bit timing fields
    localparam int WAKE_FILT_BIT = 22;
    localparam int PH2_LSB = 16;
    localparam int PH2_SEL_BIT = 15;
    localparam int TRIPLE_BIT = 14;
    localparam int PH1_LSB = 11;
    localparam int PROP_LSB = 8;
    localparam int SJW_LSB = 6;
    localparam int PRESC_LSB = 0;
    localparam logic [31:0] CFG_WMASK = 32'h0047_ffff;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // interrupt register: enables in 31-27 and 19-16, flags in 15-11 and 3-0
    localparam logic [31:0] IEN_MASK = 32'hf80f_0000;
    localparam logic [31:0] IFLAG_MASK = 32'h0000_f80f;
    localparam int SYS_ERR_FLAG_BIT = 12;
    localparam int ENABLE_SHIFT = 16;
    localparam logic [31:0] INT_RESET = 32'h0000_0000;

    // information processing time in quanta
    localparam logic [3:0] IPT_TQ = 4'h2;
    // cycles taken to wind down after the on bit is cleared
    localparam logic [3:0] SHUTDOWN_CYCLES = 4'h8;
    // largest legal data compare count
    localparam logic [4:0] DCNT_MAX = 5'h12;

    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h0,
        MODE_DISABLE = 3'h1,
        MODE_LOOPBACK = 3'h2,
        MODE_LISTEN = 3'h3,
        MODE_CONFIG = 3'h4,
        MODE_RSVD5 = 3'h5,
        MODE_RSVD6 = 3'h6,
        MODE_LISTEN_ALL = 3'h7
    } op_mode_t;

    // bit timing derived for the protocol engine
    typedef struct packed {
        logic [7:0] quantum_clocks;
        logic [3:0] propagation_segment;
        logic [3:0] phase_segment_one;
        logic [3:0] phase_segment_two;
        logic [2:0] jump_width;
        logic [4:0] quanta_per_bit;
        logic triple_sample_select;
    } bit_timing_t;

    // event pulses from the rest of the controller, flag order 15..11 then 2..0
    typedef struct packed {
        logic invalid_message;
        logic wakeup;
        logic bus_error;
        logic system_error;
        logic receive_overflow;
        logic timestamp_timer;
        logic receive_buffer;
        logic transmit_buffer;
    } can_events_t;
endpackage

// file: can_ctrl_timing_irq.sv
// can controller control, bit timing and interrupt enable block with a wishbone slave
`timescale 1ns/1ps
`default_nettype none

module can_ctrl_timing_irq
    import can_ctrl_pkg::*;
(
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    // wishbone slave
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [7:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    output logic WB_ERR_OUT,
    // system and controller status
    input wire logic SYS_IDLE_IN,
    input wire logic TRANSACTION_BUSY_IN,
    input wire logic MODE_ACHIEVED_IN,
    input wire can_events_t EVENTS_IN,
    input wire logic CAN_RX_IN,
    input wire logic CAN_RX_FILTERED_IN,
    // outputs to the protocol engine
    output logic RUN_OUT,
    output logic [2:0] REQ_MODE_OUT,
    output bit_timing_t TIMING_OUT,
    output logic [4:0] DATA_COMPARE_COUNT_OUT,
    output logic WAKE_LINE_OUT,
    output logic IRQ_OUT
);

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    logic [31:0] ctrl_r;
    logic [31:0] cfg_r;
    logic [31:0] int_r;
    logic [2:0] op_mode_r;
    logic active_r;
    logic [3:0] wind_cnt_r;
    logic on_prev_r;
    logic sys_err_r;
    logic ack_r;
    logic err_r;
    logic [31:0] rdata_r;

    logic req;
    logic hit_ctrl;
    logic hit_cfg;
    logic hit_int;
    logic mapped;
    logic do_write;
    logic [1:0] alias_sel;
    logic [31:0] lane_mask;

    // a request is not taken again in the cycle that its ack or error is driven
    assign req = WB_CYC_IN & WB_STB_IN & ~ack_r & ~err_r;
    assign alias_sel = WB_ADR_IN[3:2];
    assign hit_ctrl = (WB_ADR_IN[7:4] == CTRL_OFS[7:4]) & (WB_ADR_IN[1:0] == 2'h0);
    assign hit_cfg = (WB_ADR_IN[7:4] == CFG_OFS[7:4]) & (WB_ADR_IN[1:0] == 2'h0);
    assign hit_int = (WB_ADR_IN[7:4] == INT_OFS[7:4]) & (WB_ADR_IN[1:0] == 2'h0);
    assign mapped = hit_ctrl | hit_cfg | hit_int;
    assign do_write = req & WB_WE_IN & mapped;
    assign lane_mask = {{8{WB_SEL_IN[3]}}, {8{WB_SEL_IN[2]}}, {8{WB_SEL_IN[1]}},
                        {8{WB_SEL_IN[0]}}};

    // apply plain, clear, set or invert within the lanes and writable bits
    function automatic logic [31:0] alias_apply(input logic [31:0] old,
                                                input logic [31:0] wd,
                                                input logic [31:0] m,
                                                input logic [1:0] sel);
        logic [31:0] v;
        v = old;
        unique case (sel)
            ALIAS_PLAIN: v = wd;
            ALIAS_CLR: v = old & ~wd;
            ALIAS_SET: v = old | wd;
            ALIAS_INV: v = old ^ wd;
        endcase
        return (old & ~m) | (v & m);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // control register

    logic [31:0] ctrl_nxt;
    assign ctrl_nxt = alias_apply(ctrl_r, WB_DAT_IN, CTRL_WMASK & lane_mask, alias_sel);

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            ctrl_r <= CTRL_RESET;
        end else if (do_write && hit_ctrl) begin
            ctrl_r <= ctrl_nxt;
        end
    end

    logic module_on;
    logic halted;
    assign module_on = ctrl_r[ON_BIT];
    // stop in idle freezes the engine but keeps the registers reachable
    assign halted = ctrl_r[STOP_IDLE_BIT] & SYS_IDLE_IN;

    // wind-down after on is cleared: wait for the transaction and a minimum count
    // the minimum count lets the engine see the request even when it sits idle
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            wind_cnt_r <= 4'h0;
        end else if (module_on) begin
            wind_cnt_r <= SHUTDOWN_CYCLES;
        end else if (wind_cnt_r != 4'h0) begin
            wind_cnt_r <= wind_cnt_r - 4'h1;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            active_r <= 1'b0;
        end else if (module_on) begin
            active_r <= 1'b1;
        end else if (wind_cnt_r == 4'h0 && !TRANSACTION_BUSY_IN) begin
            active_r <= 1'b0;
        end
    end

    // mode status follows the request once the engine confirms it
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            op_mode_r <= MODE_CONFIG;
        end else if (!active_r) begin
            op_mode_r <= MODE_CONFIG;
        end else if (MODE_ACHIEVED_IN) begin
            op_mode_r <= ctrl_r[REQ_MODE_LSB +: 3];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bit timing register

    logic cfg_write_ok;
    logic [31:0] cfg_nxt;
    // outside configuration mode a timing write is acked but dropped, never delayed
    assign cfg_write_ok = (op_mode_r == MODE_CONFIG);
    assign cfg_nxt = alias_apply(cfg_r, WB_DAT_IN, CFG_WMASK & lane_mask, alias_sel);

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            cfg_r <= CFG_RESET;
        end else if (do_write && hit_cfg && cfg_write_ok) begin
            cfg_r <= cfg_nxt;
        end
    end

    logic [3:0] ph1_len;
    logic [3:0] ph2_len;
    logic [3:0] prop_len;
    logic [3:0] ph2_auto;
    assign ph1_len = {1'b0, cfg_r[PH1_LSB +: 3]} + 4'h1;
    assign prop_len = {1'b0, cfg_r[PROP_LSB +: 3]} + 4'h1;
    assign ph2_auto = (ph1_len > IPT_TQ) ? ph1_len : IPT_TQ;
    // the programmed field is ignored, not rewritten, so software reads back its value
    assign ph2_len = cfg_r[PH2_SEL_BIT] ? ({1'b0, cfg_r[PH2_LSB +: 3]} + 4'h1)
                                        : ph2_auto;

    // registered so the engine sees one settled set of lengths per clock
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            TIMING_OUT <= '0;
        end else begin
            TIMING_OUT.quantum_clocks <= {1'b0, cfg_r[PRESC_LSB +: 6], 1'b0} + 8'h02;
            TIMING_OUT.propagation_segment <= prop_len;
            TIMING_OUT.phase_segment_one <= ph1_len;
            TIMING_OUT.phase_segment_two <= ph2_len;
            TIMING_OUT.jump_width <= {1'b0, cfg_r[SJW_LSB +: 2]} + 3'h1;
            TIMING_OUT.quanta_per_bit <= 5'h01 + {1'b0, prop_len} + {1'b0, ph1_len}
                                         + {1'b0, ph2_len};
            TIMING_OUT.triple_sample_select <= cfg_r[TRIPLE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt register

    logic [31:0] int_nxt;
    logic [31:0] ev_bits;
    logic on_restart;
    assign int_nxt = alias_apply(int_r, WB_DAT_IN, (IEN_MASK | IFLAG_MASK) & lane_mask,
                                 alias_sel);
    // events land on their flag positions; the mode change flag is fed from the status
    assign ev_bits = {16'h0, EVENTS_IN.invalid_message, EVENTS_IN.wakeup,
                      EVENTS_IN.bus_error, EVENTS_IN.system_error,
                      EVENTS_IN.receive_overflow, 7'h0, 1'b0,
                      EVENTS_IN.timestamp_timer, EVENTS_IN.receive_buffer,
                      EVENTS_IN.transmit_buffer};
    // off then on clears the system error; holding on set does nothing
    assign on_restart = module_on & ~on_prev_r;

    logic mode_change;
    logic [2:0] op_mode_prev_r;
    // a change of status, not a new request, raises the mode change flag
    assign mode_change = (op_mode_r != op_mode_prev_r);

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            on_prev_r <= 1'b0;
        end else begin
            on_prev_r <= module_on;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            op_mode_prev_r <= MODE_CONFIG;
        end else begin
            op_mode_prev_r <= op_mode_r;
        end
    end

    // hardware sets win over software clears in the same cycle
    logic [31:0] int_upd;
    always_comb begin
        int_upd = int_r;
        if (do_write && hit_int) begin
            int_upd = int_nxt;
        end
        int_upd = int_upd | (ev_bits & IFLAG_MASK);
        int_upd[3] = int_upd[3] | mode_change;
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            int_r <= INT_RESET;
        end else begin
            int_r <= int_upd & (IEN_MASK | IFLAG_MASK);
        end
    end

    // system error lives apart so interrupt register writes never touch it
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            sys_err_r <= 1'b0;
        end else if (EVENTS_IN.system_error) begin
            sys_err_r <= 1'b1;
        end else if (on_restart) begin
            sys_err_r <= 1'b0;
        end
    end

    // software reads the separate system error flop in place of the stored bit
    logic [31:0] int_view;
    always_comb begin
        int_view = int_r;
        int_view[SYS_ERR_FLAG_BIT] = sys_err_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs to the engine

    logic [31:0] ctrl_view;
    always_comb begin
        ctrl_view = ctrl_r & CTRL_WMASK;
        ctrl_view[OP_MODE_LSB +: 3] = op_mode_r;
        ctrl_view[ACTIVE_BIT] = active_r;
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            RUN_OUT <= 1'b0;
        end else begin
            RUN_OUT <= active_r & ~halted;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            REQ_MODE_OUT <= MODE_CONFIG;
        end else begin
            REQ_MODE_OUT <= ctrl_r[REQ_MODE_LSB +: 3];
        end
    end

    // invalid counts are passed as the widest legal compare
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            DATA_COMPARE_COUNT_OUT <= 5'h00;
        end else begin
            DATA_COMPARE_COUNT_OUT <= (ctrl_r[DCNT_LSB +: 5] > DCNT_MAX) ? DCNT_MAX
                                      : ctrl_r[DCNT_LSB +: 5];
        end
    end

    // the bus line idles recessive, so the wake path starts high
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            WAKE_LINE_OUT <= 1'b1;
        end else begin
            WAKE_LINE_OUT <= cfg_r[WAKE_FILT_BIT] ? CAN_RX_FILTERED_IN : CAN_RX_IN;
        end
    end

    // a level: a flag left set keeps asking until it or its enable is cleared
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= |(int_view[15:0] & int_view[31:16]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus answer: one wait state, error on unmapped addresses

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            ack_r <= req & mapped;
            err_r <= req & ~mapped;
        end
    end

    // captured only on a taken read, so the data holds between accesses
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            rdata_r <= 32'h0000_0000;
        end else if (req && mapped && !WB_WE_IN) begin
            if (hit_ctrl) begin
                rdata_r <= ctrl_view;
            end else if (hit_cfg) begin
                rdata_r <= cfg_r & CFG_WMASK;
            end else begin
                rdata_r <= int_view;
            end
        end
    end

    assign WB_ACK_OUT = ack_r;
    assign WB_ERR_OUT = err_r;
    assign WB_DAT_OUT = rdata_r;

endmodule

`default_nettype wire

// file: can_ctrl_timing_irq_properties.sv
// assertion checker for the can control, timing and interrupt block
`timescale 1ns/1ps
`default_nettype none
module can_ctrl_timing_irq_properties
    import can_ctrl_pkg::*;
(
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    // bus
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [7:0] WB_ADR_IN,
    input wire logic WB_ACK_OUT,
    input wire logic WB_ERR_OUT,
    // lines and engine outputs
    input wire logic CAN_RX_IN,
    input wire logic CAN_RX_FILTERED_IN,
    input wire bit_timing_t TIMING_OUT,
    input wire logic [4:0] DATA_COMPARE_COUNT_OUT,
    input wire logic WAKE_LINE_OUT,
    input wire logic IRQ_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    logic take;
    assign take = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && !WB_ERR_OUT;
    ////////////////////////////////////////////////////////////////////////////////
    chk_ack_mapped: assert property (take && WB_ADR_IN[1:0] == 2'h0 && WB_ADR_IN[7:4] < 4'h3
        |=> WB_ACK_OUT && !WB_ERR_OUT) else $error("mapped access not acked");
    chk_err_unmapped: assert property (take && (WB_ADR_IN[1:0] != 2'h0 || WB_ADR_IN[7:4] > 4'h2)
        |=> WB_ERR_OUT && !WB_ACK_OUT) else $error("unmapped access not refused");
    chk_answer_single: assert property ((WB_ACK_OUT || WB_ERR_OUT)
        |=> !(WB_ACK_OUT || WB_ERR_OUT)) else $error("answer longer than one cycle");
    // timing outputs settle two edges after reset release
    chk_quantum_even: assert property ($past(RESETN_IN, 2) |-> TIMING_OUT.quantum_clocks[0] == 1'b0
        && TIMING_OUT.quantum_clocks inside {[2:128]}) else $error("quantum length off");
    chk_bit_total: assert property ($past(RESETN_IN, 2) |-> TIMING_OUT.quanta_per_bit ==
        1 + TIMING_OUT.propagation_segment + TIMING_OUT.phase_segment_one
        + TIMING_OUT.phase_segment_two) else $error("bit time sum wrong");
    chk_seg_range: assert property ($past(RESETN_IN, 2) |->
        TIMING_OUT.propagation_segment inside {[1:8]} && TIMING_OUT.phase_segment_one inside {[1:8]}
        && TIMING_OUT.phase_segment_two inside {[1:8]} && TIMING_OUT.jump_width inside {[1:4]})
        else $error("segment length out of range");
    chk_count_sat: assert property (DATA_COMPARE_COUNT_OUT <= DCNT_MAX)
        else $error("compare count above limit");
    chk_wake_line: assert property ($past(RESETN_IN) |-> WAKE_LINE_OUT == $past(CAN_RX_IN)
        || WAKE_LINE_OUT == $past(CAN_RX_FILTERED_IN)) else $error("wake line from nowhere");
    cover property (take && WB_WE_IN);
    cover property (WB_ERR_OUT);
    cover property ($rose(IRQ_OUT));
endmodule
bind can_ctrl_timing_irq can_ctrl_timing_irq_properties u_props (.CLK_IN, .RESETN_IN,
    .WB_CYC_IN, .WB_STB_IN, .WB_WE_IN, .WB_ADR_IN, .WB_ACK_OUT, .WB_ERR_OUT, .CAN_RX_IN,
    .CAN_RX_FILTERED_IN, .TIMING_OUT, .DATA_COMPARE_COUNT_OUT, .WAKE_LINE_OUT, .IRQ_OUT);
`default_nettype wire

// file: can_node_model.sv
// bus node model: raw and filtered receive lines for the wake path
`timescale 1ns/1ps
`default_nettype none
module can_node_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // lines seen by the controller
    output logic rx_raw_out,
    output logic rx_filt_out
);
    logic [3:0] cnt_r;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
    // raw line glitches fast, filtered copy moves slowly, so a wrong pick shows
    assign rx_raw_out = cnt_r[0] ^ cnt_r[2];
    assign rx_filt_out = cnt_r[3];
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking testbench for the can control, timing and interrupt block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import can_ctrl_pkg::*;
;
    typedef struct packed {
        logic [7:0] wa;
        logic [31:0] wd;
        logic [7:0] ra;
        logic [31:0] rd;
    } row_t;
    logic clk, rstn, cyc, stb, we, ack, errp, idle, busy, mach, raw, filt, run, wake, irq, e;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [2:0] reqm;
    logic [4:0] dcnt;
    can_events_t ev;
    bit_timing_t tim;
    int err_count, checks_done, n;
    row_t rows [9];
    logic [2:0] md [6];
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    can_ctrl_timing_irq DUT (.CLK_IN(clk), .RESETN_IN(rstn), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
        .WB_ACK_OUT(ack), .WB_ERR_OUT(errp), .SYS_IDLE_IN(idle), .TRANSACTION_BUSY_IN(busy),
        .MODE_ACHIEVED_IN(mach), .EVENTS_IN(ev), .CAN_RX_IN(raw), .CAN_RX_FILTERED_IN(filt),
        .RUN_OUT(run), .REQ_MODE_OUT(reqm), .TIMING_OUT(tim), .DATA_COMPARE_COUNT_OUT(dcnt),
        .WAKE_LINE_OUT(wake), .IRQ_OUT(irq));
    can_node_model node (.clk_in(clk), .resetn_in(rstn), .rx_raw_out(raw), .rx_filt_out(filt));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] act, input logic [31:0] exp, input string m);
        checks_done++;
        if (act !== exp) begin
            err_count++;
            $display("MISMATCH %0t %s got %h want %h", $time, m, act, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hf;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            k++;
        end while (!(ack === 1'b1 || errp === 1'b1) && k < 20);
        q = rdat;
        e = errp;
        if (k >= 20) chk(32'h0, 32'h1, "bus timeout");
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wake_chk(input logic use_filt);
        logic p;
        repeat (8) begin
            p = use_filt ? filt : raw;
            @(posedge clk);
            chk(wake, p, "wake line");
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #25000;
        err_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        results();
    end
    initial begin
        {rstn, cyc, stb, we, idle, busy, adr, wdat, err_count, checks_done} = '0;
        {mach, sel, ev} = {1'b1, 4'hf, 8'h00};
        rows = '{'{8'h10, 32'hffff_ffff, 8'h10, 32'h0047_ffff}, '{8'h14, 32'h0000_00ff, 8'h10,
            32'h0047_ff00}, '{8'h18, 32'h0000_0001, 8'h10, 32'h0047_ff01}, '{8'h1c, 32'h0040_0003,
            8'h10, 32'h0007_ff02}, '{8'h20, 32'hf80f_0000, 8'h20, 32'hf80f_0000}, '{8'h24,
            32'hf800_0000, 8'h20, 32'h000f_0000}, '{8'h00, 32'h0400_0012, 8'h00, 32'h0480_0012},
            '{8'h08, 32'h0000_2000, 8'h00, 32'h0480_2012}, '{8'h0c, 32'h0000_0003, 8'h00,
            32'h0480_2011}};
        md = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4};
        repeat (4) @(posedge clk);
        chk({reqm, wake, irq, run}, 6'h24, "reset outputs");
        rstn <= 1'b1;
        wb(1'b0, CTRL_OFS, 32'h0);
        chk(q, 32'h0480_0000, "control reset");
        wb(1'b0, INT_OFS, 32'h0);
        chk(q, 32'h0, "interrupt reset");
        foreach (rows[i]) begin
            wb(1'b1, rows[i].wa, rows[i].wd);
            wb(1'b0, rows[i].ra, 32'h0);
            chk(q, rows[i].rd, "register row");
        end
        chk(dcnt, 5'h11, "compare count");
        wb(1'b0, 8'h30, 32'h0);
        chk(e, 1'b1, "unmapped read");
        wb(1'b1, 8'h02, 32'hffff_ffff);
        chk(e, 1'b1, "misaligned write");
        wb(1'b1, CTRL_OFS, 32'h0400_2013);
        @(posedge clk);
        chk(dcnt, 5'h12, "count saturates");
        wb(1'b1, CTRL_OFS, 32'h0400_2000);
        wb(1'b1, CFG_OFS, 32'h0042_ec83);
        @(posedge clk);
        chk(tim, {8'h08, 4'h5, 4'h6, 4'h3, 3'h3, 5'h0f, 1'b1}, "free timing");
        wb(1'b1, CFG_OFS + 8'h04, 32'h0000_c000);
        @(posedge clk);
        chk(tim, {8'h08, 4'h5, 4'h6, 4'h6, 3'h3, 5'h12, 1'b0}, "auto phase two");
        wb(1'b1, CFG_OFS + 8'h04, 32'h0000_2880);
        wb(1'b1, CFG_OFS + 8'h08, 32'h0000_003f);
        @(posedge clk);
        chk(tim, {8'h80, 4'h5, 4'h1, 4'h2, 3'h1, 5'h09, 1'b0}, "ipt floor");
        wake_chk(1'b1);
        wb(1'b1, CFG_OFS + 8'h04, 32'h0040_0000);
        wake_chk(1'b0);
        wb(1'b1, CTRL_OFS + 8'h08, 32'h0000_8000);
        repeat (2) @(posedge clk);
        chk(run, 1'b1, "running");
        idle <= 1'b1;
        repeat (2) @(posedge clk);
        chk(run, 1'b0, "halt in idle");
        wb(1'b1, CTRL_OFS + 8'h04, 32'h0000_2000);
        @(posedge clk);
        chk(run, 1'b1, "run through idle");
        for (int i = 0; i < 6; i++) begin
            wb(1'b1, CTRL_OFS, 32'h0000_8000 | (32'(md[i]) << REQ_MODE_LSB));
            repeat (2) @(posedge clk);
            chk(reqm, md[i], "requested mode");
            wb(1'b0, CTRL_OFS, 32'h0);
            chk(q[23:21], md[i], "mode status");
            if (md[i] == 3'h0) begin
                wb(1'b1, CFG_OFS, 32'h0);
                wb(1'b0, CFG_OFS, 32'h0);
                chk(q, 32'h0002_043f, "timing locked");
            end
        end
        wb(1'b1, INT_OFS + 8'h08, 32'hf80f_0000);
        @(posedge clk);
        ev <= 8'hff;
        @(posedge clk);
        ev <= 8'h00;
        repeat (2) @(posedge clk);
        wb(1'b0, INT_OFS, 32'h0);
        chk({q, irq}, {32'hf80f_f80f, 1'b1}, "flags set");
        wb(1'b1, INT_OFS + 8'h04, 32'h0000_f80f);
        wb(1'b0, INT_OFS, 32'h0);
        chk(q, 32'hf80f_1000, "system flag sticks");
        wb(1'b1, INT_OFS + 8'h04, 32'h1000_0000);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0, "masked request");
        busy <= 1'b1;
        wb(1'b1, CTRL_OFS + 8'h04, 32'h0000_8000);
        repeat (4) begin
            wb(1'b0, CTRL_OFS, 32'h0);
            chk(q[ACTIVE_BIT], 1'b1, "active while finishing");
        end
        busy <= 1'b0;
        n = 0;
        do begin
            wb(1'b0, CTRL_OFS, 32'h0);
            n++;
        end while (q[ACTIVE_BIT] !== 1'b0 && n < 8);
        chk(q[ACTIVE_BIT], 1'b0, "fully disabled");
        wb(1'b1, CTRL_OFS + 8'h08, 32'h0000_8000);
        wb(1'b0, INT_OFS, 32'h0);
        chk(q[SYS_ERR_FLAG_BIT], 1'b0, "off-on clears");
        results();
    end
endmodule
`default_nettype wire
